/* File: rtl/error_out_encoder.sv */
// Encodes the collector state onto the two error outputs per selected protocol.
// Expects a stable protocol selection from the register block.
module error_out_encoder
  import fault_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_error,
  input wire logic [1:0] proto,
  input wire logic slow,
  input wire logic pol,
  input wire logic [1:0] test_val,
  output logic out0,
  output logic out1
);
  logic [31:0] cnt;
  logic phase;
  logic [31:0] half;

  assign half = slow ? SLOW_HALF_CYC : FAST_HALF_CYC;

  // Free-running toggle phase for dual-rail and time switching. The error
  // pattern below ignores it, so an indication never waits for a phase edge.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
      phase <= 1'b0;
    end
    else if (cnt >= half - 32'h1)
    begin
      cnt <= '0;
      phase <= ~phase;
    end
    else
      cnt <= cnt + 32'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      out0 <= 1'b0;
      out1 <= 1'b0;
    end
    else
    begin
      case (proto_t'(proto))
        PROTO_DUAL_RAIL:
        begin
          // Complementary toggling when healthy, equal levels on error.
          out0 <= in_error ? 1'b0 : phase;
          out1 <= in_error ? 1'b0 : ~phase;
        end
        PROTO_TIME_SWITCH:
        begin
          out0 <= in_error ? 1'b0 : phase;
          out1 <= in_error ? 1'b0 : 1'b1;
        end
        PROTO_BISTABLE:
        begin
          // Immediate: no wait on the toggle phase.
          out0 <= in_error ? ~pol : pol;
          out1 <= in_error ? pol : ~pol;
        end
        PROTO_TEST:
        begin
          out0 <= test_val[0];
          out1 <= test_val[1];
        end
        default:
        begin
          out0 <= 1'b0;
          out1 <= 1'b0;
        end
      endcase
    end
  end

  bistable_comp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ($past(proto) == 2'd2 && $past(rst_b)) |-> (out0 != out1))
    else $error("bistable outputs not complementary");
endmodule // error_out_encoder

/* File: rtl/fault_collector.sv */
// Fault collector: gathers internal faults, drives the two error outputs,
// and exposes control and status over AXI4-Lite.
// Assumes fault sources and the bus are synchronous to clk_sys.
// Functional notes
// - Any internal fault reaches the collector within ten RC clock periods.
// - Fast mode and bi-stable report a fault at once, within 64 us.
// - Slow mode may delay indication up to half a 434 Hz period.
// - Two error outputs; dual-rail, time-switching, bi-stable or test encodings.
// - After power-on reset the outputs are undriven or show error.
// - Readable error flag; software writes 1 for fault, 0 for operational.
// - Outputs return to operational only on software request.
// - In operational state at least one error output is high; the test encoding drives test_val on the outputs instead.
// - Bi-stable outputs complementary; software picks which pin is high.
// - Latest fault source stays readable, also across a functional reset.
// - After software clear, error indication holds for a configurable time.
// - Software can request a reset of the whole device.
module fault_collector
  import fault_pkg::*;
#(
  parameter int N_SRC = SRC_W,
  parameter logic [31:0] HOLD_RESET = HOLD_DEFAULT
)(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic func_rst_b,
  input wire logic [N_SRC-1:0] fault_in,
  output logic error_out_0,
  output logic error_out_1,
  output logic error_out_0_oe,
  output logic error_out_1_oe,
  output logic device_reset_req,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic fault_hit;
  logic [N_SRC-1:0] fault_vec;
  logic [31:0] ctrl;
  logic [31:0] hold_time;
  logic [31:0] hold_cnt;
  logic [N_SRC-1:0] src;
  logic err_flag;
  logic holding;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic in_error;
  logic sw_clear;
  logic sw_set;
  logic release_ev;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  fault_intake #(.N_SRC(N_SRC)) u_intake (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fault_in(fault_in),
    .fault_hit(fault_hit),
    .fault_vec(fault_vec)
  );

  // Write channel: address and data taken in either order, response after both.
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_bresp = 2'b00;

  assign sw_set = wr_go && aw_addr == STAT_OFS && w_strb[0] && w_data[STAT_ERR_BIT];
  assign sw_clear = wr_go && aw_addr == STAT_OFS && w_strb[0] && !w_data[STAT_ERR_BIT];

  // Configuration registers.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl <= CTRL_RESET_VAL;
      hold_time <= HOLD_RESET;
      irq_mask <= 2'b00;
    end
    else
    begin
      ctrl[CTRL_RESET_BIT] <= 1'b0;
      if (wr_go && aw_addr == CTRL_OFS)
        ctrl <= merge(ctrl, w_data, w_strb);
      if (wr_go && aw_addr == HOLD_OFS)
        hold_time <= merge(hold_time, w_data, w_strb);
      if (wr_go && aw_addr == IRQ_MASK_OFS && w_strb[0])
        irq_mask <= w_data[1:0];
    end
  end

  assign device_reset_req = ctrl[CTRL_RESET_BIT];

  // Error flag: a fault wins over a simultaneous software clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      err_flag <= 1'b1;
    else if (fault_hit || sw_set)
      err_flag <= 1'b1;
    else if (sw_clear)
      err_flag <= 1'b0;
  end

  // Hold the outputs in error after a clear for hold_time cycles.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      holding <= 1'b0;
      hold_cnt <= 32'h0000_0000;
    end
    else if (fault_hit || sw_set)
      holding <= 1'b0;
    else if (sw_clear && err_flag)
    begin
      holding <= hold_time != 32'h0000_0000;
      hold_cnt <= hold_time;
    end
    else if (holding)
    begin
      hold_cnt <= hold_cnt - 32'h1;
      if (hold_cnt <= 32'h1)
        holding <= 1'b0;
    end
  end

  assign in_error = err_flag || holding;
  assign release_ev = holding && hold_cnt <= 32'h1 && !fault_hit && !sw_set;

  // Source capture survives the functional reset; only power-on reset clears it.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      src <= '0;
    else if (fault_hit)
      src <= fault_vec;
  end

  // Interrupt status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      irq_stat <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
        if (wr_go && aw_addr == IRQ_STAT_OFS && w_strb[0] && w_data[i])
          irq_stat[i] <= 1'b0;
      if (fault_hit)
        irq_stat[IRQ_FAULT_BIT] <= 1'b1;
      if (release_ev)
        irq_stat[IRQ_RELEASE_BIT] <= 1'b1;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read channel.
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        CTRL_OFS: s_axi_rdata <= ctrl;
        STAT_OFS: s_axi_rdata <= {30'h0, holding, err_flag};
        HOLD_OFS: s_axi_rdata <= hold_time;
        SRC_OFS: s_axi_rdata <= 32'(src);
        IRQ_STAT_OFS: s_axi_rdata <= {30'h0, irq_stat};
        IRQ_MASK_OFS: s_axi_rdata <= {30'h0, irq_mask};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  error_out_encoder u_enc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_error(in_error),
    .proto(ctrl[CTRL_PROTO_LSB +: 2]),
    .slow(ctrl[CTRL_SLOW_BIT]),
    .pol(ctrl[CTRL_POL_BIT]),
    .test_val({ctrl[CTRL_TEST1_BIT], ctrl[CTRL_TEST0_BIT]}),
    .out0(error_out_0),
    .out1(error_out_1)
  );

  // Pins are driven from power-on, since CTRL_RESET_VAL sets the drive bit; software can float them.
  // The functional reset gates the drivers off while it is held.
  assign error_out_0_oe = ctrl[CTRL_DRIVE_BIT] && func_rst_b;
  assign error_out_1_oe = ctrl[CTRL_DRIVE_BIT] && func_rst_b;

  no_auto_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(err_flag) |-> $past(sw_clear))
    else $error("error flag cleared without software request");

  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault_hit |=> err_flag)
    else $error("fault accepted without setting error flag");

  sw_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sw_set |=> err_flag) and (sw_clear && !fault_hit |=> !err_flag))
    else $error("software write of error flag not honoured");

  hold_time_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sw_clear && err_flag && !fault_hit && hold_time > 32'h2) |=> holding [*2])
    else $error("error indication released before hold time");

  ops_high_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!in_error && $past(!in_error, 2) && $past(rst_b, 2) && ctrl[1:0] != 2'd3
     && $stable(ctrl)) |-> (error_out_0 || error_out_1))
    else $error("no error output high in operational state");

  src_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !fault_hit |=> $stable(src))
    else $error("fault source changed without a fault");

  fast_ind_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (fault_hit && ctrl[1:0] == 2'd2 && $stable(ctrl)) |-> ##2
    (error_out_0 == ctrl[CTRL_POL_BIT] ^ 1'b1))
    else $error("bistable fault indication late");

  reset_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    device_reset_req |=> !device_reset_req)
    else $error("device reset request not a single pulse");
endmodule // fault_collector

/* File: rtl/fault_intake.sv */
// Synchronises and latches fault requests from the safety mechanisms.
// Sources are level or pulse, synchronous to clk_sys.
module fault_intake
  import fault_pkg::*;
#(
  parameter int N_SRC = SRC_W
)(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [N_SRC-1:0] fault_in,
  output logic fault_hit,
  output logic [N_SRC-1:0] fault_vec
);
  logic [N_SRC-1:0] fault_q;

  // Two register stages put the path to the collector at two cycles.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      fault_q <= '0;
    else
      fault_q <= fault_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      fault_hit <= 1'b0;
      fault_vec <= '0;
    end
    else
    begin
      fault_hit <= |fault_q;
      fault_vec <= fault_q;
    end
  end

  fault_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (|fault_in) |-> ##2 fault_hit)
    else $error("fault not collected within two cycles");
endmodule // fault_intake

/* File: rtl/fault_pkg.sv */
// Constants for the fault collector: register map, field positions, timing counts.
// Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
package fault_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RC_HZ = 16_000_000;
  // Fault transport limit: 10 periods of the 16 MHz RC clock.
  localparam int unsigned RC_LIMIT_PERIODS = 10;
  localparam int unsigned FAULT_LATENCY_CYC = (RC_LIMIT_PERIODS * CLK_HZ) / RC_HZ;
  // Fast indication limit of 64 us.
  localparam int unsigned FAST_LIMIT_US = 64;
  localparam int unsigned FAST_LIMIT_CYC = FAST_LIMIT_US * (CLK_HZ / 1_000_000);
  // Slow toggling frequency 434 Hz: half period in system cycles.
  localparam int unsigned SLOW_HZ = 434;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  // Fast toggling half period kept well inside the fast limit.
  localparam int unsigned FAST_HALF_CYC = FAST_LIMIT_CYC / 4;
  localparam int unsigned HOLD_DEFAULT = 32'h0000_1000;
  localparam int unsigned SRC_W = 8;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] HOLD_OFS = 8'h08;
  localparam logic [7:0] SRC_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // CTRL fields.
  localparam int CTRL_PROTO_LSB = 0;
  localparam int CTRL_SLOW_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_TEST0_BIT = 4;
  localparam int CTRL_TEST1_BIT = 5;
  localparam int CTRL_DRIVE_BIT = 6;
  localparam int CTRL_RESET_BIT = 31;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0040;
  // STAT fields.
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  // IRQ status fields.
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_RELEASE_BIT = 1;

  typedef enum logic [1:0] {
    PROTO_DUAL_RAIL,
    PROTO_TIME_SWITCH,
    PROTO_BISTABLE,
    PROTO_TEST
  } proto_t;
endpackage

/* File: verif/error_out_monitor.sv */
// Model of the external safety monitor watching the two error outputs.
// Assumes the bench tells it which protocol and polarity are in use.
module error_out_monitor
(
  input wire logic clk_sys,
  input wire logic arm,
  input wire logic [1:0] proto,
  input wire logic pol,
  input wire logic o0,
  input wire logic o1,
  input wire logic oe0,
  input wire logic oe1,
  output logic safe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bad;
  // An undriven pin is not trusted either, so it counts as an error.
  always_comb
  begin
    bad = !(oe0 && oe1);
    if (proto == 2'h2)
      bad = bad || ({o1, o0} == {pol, !pol});
    else if (proto != 2'h3)
      bad = bad || ({o1, o0} == 2'h0);
  end
  // Once tripped the monitor stays safe until the bench rearms it.
  always_ff @(posedge clk_sys)
  begin
    if (arm)
      safe <= 1'b0;
    else if (bad)
      safe <= 1'b1;
  end
endmodule // error_out_monitor

/* File: verif/fault_collector_tb_top.sv */
// Self-checking bench for the fault collector.
// Assumes one 100 MHz clock and register access over AXI4-Lite.
module fault_collector_tb_top
  import fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, func_rst_b, arm, pol, safe;
  logic rs_seen = 1'b0;
  logic [7:0] fin, awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, proto;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, o0, o1, oe0, oe1, drq, irq;
  int errors = 0;
  int n_tests = 0;
  logic [31:0] ctl [6] = '{32'h40, 32'h41, 32'h4A, 32'h42, 32'h53, 32'h63};
  logic [1:0] ex [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};

  fault_collector i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .func_rst_b(func_rst_b),
    .fault_in(fin), .error_out_0(o0), .error_out_1(o1), .error_out_0_oe(oe0),
    .error_out_1_oe(oe1), .device_reset_req(drq), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  error_out_monitor i_mon (.clk_sys(clk_sys), .arm(arm), .proto(proto), .pol(pol),
    .o0(o0), .o1(o1), .oe0(oe0), .oe1(oe1), .safe(safe));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit pa = 1;
    bit pw = 1;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk_sys);
      if (pa && awready === 1'b1)
      begin
        pa = 0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 0;
        wvalid <= 1'b0;
      end
    end
    do
      @(posedge clk_sys);
    while (bvalid !== 1'b1);
    chk("bresp", {30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk_sys);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge clk_sys);
    while (rvalid !== 1'b1);
    chk(nm, rdata, e);
    chk("rresp", {30'h0, rresp}, 32'h0);
    rready <= 1'b0;
  endtask

  task automatic pins(input logic [1:0] e);
    chk("pins", {30'h0, o1, o0}, {30'h0, e});
  endtask

  task automatic irqc(input logic e);
    cyc(2);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask

  task automatic end_sim();
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // The whole sequence needs a little over five hundred cycles.
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  always @(posedge clk_sys)
    if (drq === 1'b1)
      rs_seen <= 1'b1;

  initial
  begin
    int n;
    rst_b = 1'b0;
    func_rst_b = 1'b1;
    {arm, pol, fin, proto} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("oe", {30'h0, oe1, oe0}, 32'h3);
    pins(2'h0);
    rc(STAT_OFS, 32'h1, "stat");
    rc(CTRL_OFS, CTRL_RESET_VAL, "ctrl");
    rc(HOLD_OFS, HOLD_DEFAULT, "hold");
    rc(8'h20, 32'h0, "unmapped");
    wr(HOLD_OFS, 32'h14);
    wr(IRQ_MASK_OFS, 32'h3);
    wr(CTRL_OFS, 32'h4A);
    wr(STAT_OFS, 32'h0);
    rc(STAT_OFS, 32'h2, "holding");
    pins(2'h2);
    cyc(40);
    pins(2'h1);
    irqc(1'b1);
    rc(IRQ_STAT_OFS, 32'h2, "irq_stat");
    wr(IRQ_STAT_OFS, 32'h2);
    irqc(1'b0);
    foreach (ctl[i])
    begin
      wr(CTRL_OFS, ctl[i]);
      cyc(4);
      if (i == 0)
        chk("dual", {31'h0, o0 ^ o1}, 32'h1);
      else if (i == 1)
        chk("time", {31'h0, o1}, 32'h1);
      else
        pins(ex[i]);
      if (i < 4)
        chk("ok_high", {31'h0, o0 | o1}, 32'h1);
    end
    wr(CTRL_OFS, 32'h4A);
    proto <= 2'h2;
    pol <= 1'b1;
    cyc(4);
    arm <= 1'b1;
    cyc(1);
    arm <= 1'b0;
    fin <= 8'h08;
    cyc(1);
    fin <= 8'h00;
    n = 1;
    while ({o1, o0} !== 2'h2 && n < FAST_LIMIT_CYC)
    begin
      cyc(1);
      n++;
    end
    chk("latency", n <= FAULT_LATENCY_CYC, 32'h1);
    irqc(1'b1);
    chk("safe", {31'h0, safe}, 32'h1);
    rc(STAT_OFS, 32'h1, "err_flag");
    rc(SRC_OFS, 32'h8, "src");
    rc(IRQ_STAT_OFS, 32'h1, "irq_stat");
    cyc(200);
    pins(2'h2);
    func_rst_b <= 1'b0;
    cyc(2);
    chk("oe", {30'h0, oe1, oe0}, 32'h0);
    rc(SRC_OFS, 32'h8, "src");
    func_rst_b <= 1'b1;
    cyc(2);
    chk("oe", {30'h0, oe1, oe0}, 32'h3);
    rc(SRC_OFS, 32'h8, "src");
    wr(IRQ_MASK_OFS, 32'h0);
    irqc(1'b0);
    wr(IRQ_MASK_OFS, 32'h3);
    irqc(1'b1);
    wr(IRQ_STAT_OFS, 32'h1);
    irqc(1'b0);
    wr(STAT_OFS, 32'h0);
    cyc(40);
    pins(2'h1);
    wr(STAT_OFS, 32'h1);
    cyc(4);
    pins(2'h2);
    rc(STAT_OFS, 32'h1, "stat");
    wr(CTRL_OFS, 32'h8000_004A);
    cyc(2);
    chk("reset_req", {31'h0, rs_seen}, 32'h1);
    rc(CTRL_OFS, 32'h4A, "ctrl");
    // Slow dual-rail: the error pattern must not wait for the slow toggle phase.
    wr(CTRL_OFS, 32'h44);
    cyc(4);
    pins(2'h0);
    wr(STAT_OFS, 32'h0);
    cyc(40);
    chk("slow_dual", {31'h0, o0 ^ o1}, 32'h1);
    fin <= 8'h01;
    cyc(1);
    fin <= 8'h00;
    cyc(6);
    pins(2'h0);
    rc(SRC_OFS, 32'h1, "src");
    wr(CTRL_OFS, 32'h41);
    cyc(4);
    pins(2'h0);
    end_sim();
  end
endmodule // fault_collector_tb_top
